// ===== rtl/flash_timing_pkg.sv
// Purpose: Shared constants and types for the serial flash timing block.
// Assumes: System clock of 40 MHz.
// Notes:   Cycle counts follow from the maximum times and the clock rate.
`default_nettype none
package flash_timing_pkg;

    // ======================================================================
    // Clock rate
    // ======================================================================
    localparam int unsigned CLK_MHZ     = 40;

    // ======================================================================
    // Times in their own units
    // ======================================================================
    localparam int unsigned T_WP_US     = 1;
    localparam int unsigned T_DPD_US    = 3;
    localparam int unsigned T_RDPD_US   = 35;
    localparam int unsigned T_XFER_US   = 200;
    localparam int unsigned T_COMP_US   = 200;
    localparam int unsigned T_EP_MS     = 35;
    localparam int unsigned T_P_MS      = 4;
    localparam int unsigned T_PE_MS     = 32;
    localparam int unsigned T_BE_MS     = 35;
    localparam int unsigned T_SE_MS     = 700;
    localparam int unsigned T_CE_S      = 6;

    // ======================================================================
    // Longest times as cycle counts (rounded down, exact at 40 MHz)
    // ======================================================================
    localparam int unsigned WP_CYC      = T_WP_US * CLK_MHZ;
    localparam int unsigned DPD_CYC     = T_DPD_US * CLK_MHZ;
    localparam int unsigned RDPD_CYC    = T_RDPD_US * CLK_MHZ;
    localparam int unsigned XFER_CYC    = T_XFER_US * CLK_MHZ;
    localparam int unsigned COMP_CYC    = T_COMP_US * CLK_MHZ;
    localparam int unsigned EP_CYC      = T_EP_MS * 1000 * CLK_MHZ;
    localparam int unsigned P_CYC       = T_P_MS * 1000 * CLK_MHZ;
    localparam int unsigned PE_CYC      = T_PE_MS * 1000 * CLK_MHZ;
    localparam int unsigned BE_CYC      = T_BE_MS * 1000 * CLK_MHZ;
    localparam int unsigned SE_CYC      = T_SE_MS * 1000 * CLK_MHZ;
    localparam int unsigned CE_CYC      = T_CE_S * 1000000 * CLK_MHZ;

    // ======================================================================
    // Page sizes and widths
    // ======================================================================
    localparam int unsigned PAGE_STD    = 264;
    localparam int unsigned PAGE_BIN    = 256;
    localparam int unsigned TMR_W       = 32;
    localparam int unsigned BYTE_W      = 8;

    // ======================================================================
    // Self-timed operation kinds
    // ======================================================================
    typedef enum logic [3:0] {
        OP_XFER,
        OP_COMP,
        OP_ERASE_PROG,
        OP_PROG,
        OP_ERASE,
        OP_BLOCK_ERASE,
        OP_SECTOR_ERASE,
        OP_CHIP_ERASE,
        OP_PDOWN,
        OP_RESUME
    } op_t;

endpackage
`default_nettype wire

// ===== rtl/op_timer.sv
// Purpose: Down counter that times one self-timed operation.
// Assumes: Load is ignored while a count is running.
// Notes:   Busy stands for exactly the loaded number of cycles, and for one cycle when zero is loaded.
`timescale 1ns/1ps
`default_nettype none
module op_timer #(
    parameter int unsigned W = 32
) (
    // Clock and reset
    input  wire logic         sys_clk_i,
    input  wire logic         resetn_i,
    // Control
    input  wire logic         load_i,
    input  wire logic [W-1:0] count_i,
    // Status
    output logic              busy_o,
    output logic              done_o
);

    logic [W-1:0] cnt_q, cnt_d;
    logic         busy_q, busy_d;
    logic         done_q, done_d;

    // Next count; a zero load ends like a load of one so busy always shows.
    always_comb begin
        cnt_d  = cnt_q;
        busy_d = busy_q;
        done_d = 1'b0;
        if (busy_q) begin
            if (cnt_q <= {{(W-1){1'b0}}, 1'b1}) begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end else begin
                cnt_d = cnt_q - {{(W-1){1'b0}}, 1'b1};
            end
        end else if (load_i) begin
            cnt_d  = count_i;
            busy_d = 1'b1;
        end
    end

    // Register stage.
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            cnt_q  <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign busy_o = busy_q;
    assign done_o = done_q;

endmodule
`default_nettype wire

// ===== rtl/serial_flash_op_timing.sv
// Purpose: Serial link front end and self-timed operation sequencer of a page flash.
// Assumes: Link pins are asynchronous to sys_clk_i and are oversampled by it.
// Notes:   The link clock must stay well below a quarter of sys_clk_i here.
//
// Behaviour
// - Output bits change on falling link clock, input bits captured on rising.
// - Transactions start correctly with link clock idle low or high.
// - Page-to-buffer transfer or compare ends within 200 us of select release.
// - Erase-program 35 ms, program 4 ms, erase 32 ms at most.
// - Block erase 35 ms, sector 700 ms, chip 6 s at most.
// - Write protection engages and releases within 1 us of pin change.
// - Deep power-down reached within 3 us after select release.
// - Standby regained within 35 us after resume; host waits that long.
// - Page size starts at 264 bytes unless factory set; may become 256.
`timescale 1ns/1ps
`default_nettype none
module serial_flash_op_timing
    import flash_timing_pkg::*;
#(
    parameter bit          FACTORY_256 = 1'b0,
    parameter int unsigned XFER_CYCLES = flash_timing_pkg::XFER_CYC,
    parameter int unsigned COMP_CYCLES = flash_timing_pkg::COMP_CYC,
    parameter int unsigned EP_CYCLES   = flash_timing_pkg::EP_CYC,
    parameter int unsigned P_CYCLES    = flash_timing_pkg::P_CYC,
    parameter int unsigned PE_CYCLES   = flash_timing_pkg::PE_CYC,
    parameter int unsigned BE_CYCLES   = flash_timing_pkg::BE_CYC,
    parameter int unsigned SE_CYCLES   = flash_timing_pkg::SE_CYC,
    parameter int unsigned CE_CYCLES   = flash_timing_pkg::CE_CYC
) (
    // Clock and reset
    input  wire logic                          sys_clk_i,
    input  wire logic                          resetn_i,
    // Serial link pins
    input  wire logic                          cs_n_i,
    input  wire logic                          sck_i,
    input  wire logic                          si_i,
    output logic                               so_o,
    output logic                               so_oe_n_o,
    input  wire logic                          wp_n_i,
    // Byte stream to and from the core
    output logic [flash_timing_pkg::BYTE_W-1:0] rx_byte_o,
    output logic                               rx_valid_o,
    input  wire logic [flash_timing_pkg::BYTE_W-1:0] tx_byte_i,
    // Operation requests and status
    input  wire logic                          op_req_i,
    input  wire flash_timing_pkg::op_t         op_kind_i,
    output logic                               op_armed_o,
    output logic                               busy_o,
    output logic                               op_done_o,
    output logic                               op_refused_o,
    output logic                               protect_o,
    output logic                               powered_down_o,
    // Page size configuration
    input  wire logic                          page_256_set_i,
    output logic                               page_256_o
);

    // ======================================================================
    // Pin synchronisers
    // ======================================================================
    logic [2:0] sck_q, cs_q;
    logic [1:0] si_q, wp_q;

    // Each pin passes two flip-flops; the third stage of sck and cs feeds edge finding.
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            sck_q <= 3'h0;
            cs_q  <= 3'h7;
            si_q  <= 2'h0;
            wp_q  <= 2'h3;
        end else begin
            sck_q <= {sck_q[1:0], sck_i};
            cs_q  <= {cs_q[1:0], cs_n_i};
            si_q  <= {si_q[0], si_i};
            wp_q  <= {wp_q[0], wp_n_i};
        end
    end

    logic sck_rise, sck_fall, cs_fall, cs_rise, sel;
    assign sck_rise = sck_q[1] & ~sck_q[2];
    assign sck_fall = ~sck_q[1] & sck_q[2];
    assign cs_fall  = ~cs_q[1] & cs_q[2];
    assign cs_rise  = cs_q[1] & ~cs_q[2];
    assign sel      = ~cs_q[1];

    // ======================================================================
    // Serial shifter
    // ======================================================================
    logic [7:0] rx_sr_q, rx_sr_d, tx_sr_q, tx_sr_d, rx_byte_q, rx_byte_d;
    logic [2:0] bit_q, bit_d;
    logic       rose_q, rose_d, so_q, so_d, oe_n_q, oe_n_d, rxv_q, rxv_d;

    // A falling edge shifts only after a rising one, so mode 3 idle-high start is harmless.
    always_comb begin
        rx_sr_d   = rx_sr_q;
        tx_sr_d   = tx_sr_q;
        rx_byte_d = rx_byte_q;
        bit_d     = bit_q;
        rose_d    = rose_q;
        so_d      = so_q;
        oe_n_d    = oe_n_q;
        rxv_d     = 1'b0;
        if (cs_fall) begin
            tx_sr_d = tx_byte_i;
            so_d    = tx_byte_i[7];
            oe_n_d  = 1'b0;
            bit_d   = 3'h0;
            rose_d  = 1'b0;
        end else if (!sel) begin
            oe_n_d  = 1'b1;
            rose_d  = 1'b0;
        end else if (sck_rise) begin
            rx_sr_d = {rx_sr_q[6:0], si_q[1]};
            bit_d   = bit_q + 3'h1;
            rose_d  = 1'b1;
            if (bit_q == 3'h7) begin
                rx_byte_d = {rx_sr_q[6:0], si_q[1]};
                rxv_d     = 1'b1;
            end
        end else if (sck_fall && rose_q) begin
            if (bit_q == 3'h0) begin
                tx_sr_d = tx_byte_i;
            end else begin
                tx_sr_d = {tx_sr_q[6:0], 1'b0};
            end
            so_d = tx_sr_d[7];
        end
    end

    // Register stage of the shifter.
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            rx_sr_q   <= 8'h00;
            tx_sr_q   <= 8'h00;
            rx_byte_q <= 8'h00;
            bit_q     <= 3'h0;
            rose_q    <= 1'b0;
            so_q      <= 1'b0;
            oe_n_q    <= 1'b1;
            rxv_q     <= 1'b0;
        end else begin
            rx_sr_q   <= rx_sr_d;
            tx_sr_q   <= tx_sr_d;
            rx_byte_q <= rx_byte_d;
            bit_q     <= bit_d;
            rose_q    <= rose_d;
            so_q      <= so_d;
            oe_n_q    <= oe_n_d;
            rxv_q     <= rxv_d;
        end
    end

    // ======================================================================
    // Operation sequencer
    // ======================================================================
    op_t              pend_kind_q, pend_kind_d, cur_kind_q, cur_kind_d;
    logic             armed_q, armed_d, dpd_q, dpd_d, ref_q, ref_d;
    logic             prot_q, prot_d, p256_q, p256_d, load;
    logic [TMR_W-1:0] load_cnt;
    logic             tmr_busy, tmr_done, writes;

    // Duration of each kind; finishing at the longest time keeps the host's view safe.
    always_comb begin
        case (pend_kind_q)
            OP_XFER:         load_cnt = TMR_W'(XFER_CYCLES);
            OP_COMP:         load_cnt = TMR_W'(COMP_CYCLES);
            OP_ERASE_PROG:   load_cnt = TMR_W'(EP_CYCLES);
            OP_PROG:         load_cnt = TMR_W'(P_CYCLES);
            OP_ERASE:        load_cnt = TMR_W'(PE_CYCLES);
            OP_BLOCK_ERASE:  load_cnt = TMR_W'(BE_CYCLES);
            OP_SECTOR_ERASE: load_cnt = TMR_W'(SE_CYCLES);
            OP_CHIP_ERASE:   load_cnt = TMR_W'(CE_CYCLES);
            OP_PDOWN:        load_cnt = TMR_W'(DPD_CYC);
            OP_RESUME:       load_cnt = TMR_W'(RDPD_CYC);
            default:         load_cnt = TMR_W'(1);
        endcase
        writes = (pend_kind_q >= OP_ERASE_PROG) && (pend_kind_q <= OP_CHIP_ERASE);
    end

    // An armed operation starts when select is released; protected writes are refused.
    always_comb begin
        pend_kind_d = pend_kind_q;
        cur_kind_d  = cur_kind_q;
        armed_d     = armed_q;
        dpd_d       = dpd_q;
        ref_d       = 1'b0;
        load        = 1'b0;
        prot_d      = ~wp_q[1];
        p256_d      = p256_q | page_256_set_i;
        if (op_req_i && !armed_q && !tmr_busy) begin
            pend_kind_d = op_kind_i;
            armed_d     = 1'b1;
        end
        if (armed_q && cs_rise) begin
            armed_d = 1'b0;
            if (writes && prot_q) begin
                ref_d = 1'b1;
            end else begin
                load       = 1'b1;
                cur_kind_d = pend_kind_q;
            end
        end
        if (tmr_done) begin
            if (cur_kind_q == OP_PDOWN) begin
                dpd_d = 1'b1;
            end else if (cur_kind_q == OP_RESUME) begin
                dpd_d = 1'b0;
            end
        end
    end

    // Register stage of the sequencer; page size takes the factory setting at reset.
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            pend_kind_q <= OP_XFER;
            cur_kind_q  <= OP_XFER;
            armed_q     <= 1'b0;
            dpd_q       <= 1'b0;
            ref_q       <= 1'b0;
            prot_q      <= 1'b0;
            p256_q      <= FACTORY_256;
        end else begin
            pend_kind_q <= pend_kind_d;
            cur_kind_q  <= cur_kind_d;
            armed_q     <= armed_d;
            dpd_q       <= dpd_d;
            ref_q       <= ref_d;
            prot_q      <= prot_d;
            p256_q      <= p256_d;
        end
    end

    op_timer #(.W(TMR_W)) u_timer (
        .sys_clk_i (sys_clk_i),
        .resetn_i  (resetn_i),
        .load_i    (load),
        .count_i   (load_cnt),
        .busy_o    (tmr_busy),
        .done_o    (tmr_done)
    );

    // ======================================================================
    // Outputs
    // ======================================================================
    assign so_o           = so_q;
    assign so_oe_n_o      = oe_n_q;
    assign rx_byte_o      = rx_byte_q;
    assign rx_valid_o     = rxv_q;
    assign op_armed_o     = armed_q;
    assign busy_o         = tmr_busy;
    assign op_done_o      = tmr_done;
    assign op_refused_o   = ref_q;
    assign protect_o      = prot_q;
    assign powered_down_o = dpd_q;
    assign page_256_o     = p256_q;

    // ======================================================================
    // Checks
    // ======================================================================
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    a_out_on_fall: assert property (sel && $past(sel) && $changed(so_q) |-> $past(sck_fall) || $past(cs_fall))
        else $error("Serial output changed away from a falling edge.");
    a_in_on_rise: assert property (rxv_q |-> $past(sck_rise))
        else $error("Byte completed without a rising edge.");
    a_mode3_start: assert property (cs_fall |=> !rose_q ##0 so_q == $past(tx_byte_i[7]))
        else $error("First output bit not presented at select.");
    a_prot_follow: assert property ($fell(wp_q[1]) |=> prot_q)
        else $error("Write protection not engaged after pin low.");
    a_prot_release: assert property ($rose(wp_q[1]) |=> !prot_q)
        else $error("Write protection not released after pin high.");
    a_xfer_start: assert property (armed_q && cs_rise && pend_kind_q == OP_XFER && !tmr_busy |=> tmr_busy)
        else $error("Transfer did not start at select release.");
    a_pdown_time: assert property (load && pend_kind_q == OP_PDOWN |-> ##[1:122] dpd_q)
        else $error("Deep power-down not reached in time.");
    a_refuse_write: assert property (armed_q && cs_rise && writes && prot_q |=> ref_q && !tmr_busy)
        else $error("Protected write was not refused.");
    a_page_sticky: assert property (p256_q |=> p256_q)
        else $error("Page size fell back from 256 bytes.");

endmodule
`default_nettype wire

// ===== verification/host_link_model.sv
// Purpose: Behavioural host controller that drives the serial link pins.
// Assumes: One byte per frame; half period of the link clock in ns.
// Notes:   The link clock stands still outside frames.
`timescale 1ns/1ps
`default_nettype none
module host_link_model #(
    parameter int unsigned HALF_NS = 100
) (
    // Link pins towards the memory
    output logic      cs_n_o,
    output logic      sck_o,
    output logic      si_o,
    input  wire logic so_i
);
    // ======================================================================
    // Frame driver
    // ======================================================================
    // Pins start deselected with the link clock parked low.
    initial begin
        cs_n_o = 1'b1;
        sck_o  = 1'b0;
        si_o   = 1'b0;
    end

    // One byte in mode 0 or mode 3; the closing mode 3 rise is a partial bit.
    task automatic xfer(input bit mode3, input logic [7:0] mosi, output logic [7:0] miso);
        miso = 8'h00;
        #7;
        sck_o = mode3;
        #(HALF_NS);
        cs_n_o = 1'b0;
        si_o   = mosi[7];
        #(HALF_NS);
        if (mode3) begin
            sck_o = 1'b0;
            #(HALF_NS);
        end
        for (int i = 7; i >= 0; i--) begin
            sck_o = 1'b1;
            // Data moves a little after the rise so the sampler sees the old bit first.
            #(HALF_NS / 2);
            if (i > 0) begin
                si_o = mosi[i-1];
            end
            #(HALF_NS / 2);
            sck_o   = 1'b0;
            miso[i] = so_i;
            #(HALF_NS);
        end
        sck_o = mode3;
        #(HALF_NS);
        cs_n_o = 1'b1;
        si_o   = ~si_o;
        #(HALF_NS);
    endtask
endmodule
`default_nettype wire

// ===== verification/tb.sv
// Purpose: Self-checking bench for the serial flash timing block.
// Assumes: Short operation counts are given through the parameters.
// Notes:   Power-down and resume counts run at full length.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import flash_timing_pkg::*;

    typedef struct {
        bit          m3;
        logic [7:0]  mosi;
        logic [7:0]  tx;
        op_t         kind;
        int unsigned n;
    } row_t;

    // ======================================================================
    // Signals and counters
    // ======================================================================
    localparam int DLY = 2;
    localparam int unsigned N_XFER = 20, N_COMP = 21, N_EP = 22, N_P = 23, N_PE = 24;
    localparam int unsigned N_BE = 25, N_SE = 26, N_CE = 27, REWRITE_SPAN = 10000;
    logic        clk, resetn, cs_n, sck, si, so, so_oe_n, wp_n, rx_valid, op_req, op_armed;
    logic        busy, op_done, op_refused, protect, pdown, page_set, page_256, done_at_fall;
    logic [7:0]  rx_byte, tx_byte, miso;
    op_t         op_kind;
    int          errors, num_checks;
    int unsigned ops_seen, last_len, busy_cnt, rx_pulses, refusals, mark, prev;
    int unsigned oe_cnt, oe_mark, rewrite_ptr;
    row_t        rows [8] = '{
        '{1'b0, 8'hA5, 8'h3C, OP_XFER, N_XFER}, '{1'b1, 8'h5A, 8'hC3, OP_COMP, N_COMP},
        '{1'b0, 8'h00, 8'hFF, OP_ERASE_PROG, N_EP}, '{1'b1, 8'hFF, 8'h00, OP_PROG, N_P},
        '{1'b0, 8'h81, 8'h7E, OP_ERASE, N_PE}, '{1'b1, 8'h7E, 8'h81, OP_BLOCK_ERASE, N_BE},
        '{1'b0, 8'h01, 8'h80, OP_SECTOR_ERASE, N_SE}, '{1'b1, 8'h80, 8'h01, OP_CHIP_ERASE, N_CE}};

    // The 40 MHz system clock.
    initial clk = 1'b0;
    always #12.5 clk = ~clk;

    host_link_model host_u (.cs_n_o(cs_n), .sck_o(sck), .si_o(si), .so_i(so));

    // Standard parts keep the default page size; all counts but power-down and resume are shortened.
    serial_flash_op_timing #(
        .XFER_CYCLES(N_XFER), .COMP_CYCLES(N_COMP), .EP_CYCLES(N_EP), .P_CYCLES(N_P),
        .PE_CYCLES(N_PE), .BE_CYCLES(N_BE), .SE_CYCLES(N_SE), .CE_CYCLES(N_CE)
    ) dut_u (
        .sys_clk_i(clk), .resetn_i(resetn), .cs_n_i(cs_n), .sck_i(sck), .si_i(si), .so_o(so),
        .so_oe_n_o(so_oe_n), .wp_n_i(wp_n), .rx_byte_o(rx_byte), .rx_valid_o(rx_valid),
        .tx_byte_i(tx_byte), .op_req_i(op_req), .op_kind_i(op_kind), .op_armed_o(op_armed),
        .busy_o(busy), .op_done_o(op_done), .op_refused_o(op_refused), .protect_o(protect),
        .powered_down_o(pdown), .page_256_set_i(page_set), .page_256_o(page_256)
    );

    // Counts busy runs and pulses at the edge, before the registers move.
    always @(posedge clk) begin
        if (busy === 1'b1) begin
            busy_cnt = busy_cnt + 1;
        end else if (busy_cnt != 0) begin
            last_len     = busy_cnt;
            done_at_fall = op_done;
            busy_cnt     = 0;
            ops_seen     = ops_seen + 1;
        end
        rx_pulses = rx_pulses + ((rx_valid === 1'b1) ? 1 : 0);
        refusals  = refusals + ((op_refused === 1'b1) ? 1 : 0);
        oe_cnt    = oe_cnt + ((so_oe_n === 1'b0) ? 1 : 0);
    end

    // ======================================================================
    // Tasks
    // ======================================================================
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    // Inputs move a fixed delay after the edge so no race with the design.
    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #DLY;
    endtask

    task automatic arm(input op_t k);
        cycles(1);
        op_req  = 1'b1;
        op_kind = k;
        // Each program or erase advances the host's page rewrite pointer.
        if (k >= OP_ERASE_PROG && k <= OP_CHIP_ERASE) begin
            rewrite_ptr++;
        end
        cycles(1);
        op_req = 1'b0;
        check("op_armed", op_armed, 1);
    endtask

    task automatic frame(input bit m3, input logic [7:0] out);
        host_u.xfer(m3, out, miso);
        cycles(1);
    endtask

    task automatic wait_op(input int unsigned p);
        for (int w = 0; w < 2000 && ops_seen == p; w++) begin
            cycles(1);
        end
        check("op_end", ops_seen, p + 1);
    endtask

    task end_of_test;
        if (errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // A hang is cut short well past the expected run of about 100 us.
    initial begin
        #400000;
        errors++;
        end_of_test();
    end

    // ======================================================================
    // Main sequence
    // ======================================================================
    initial begin
        {resetn, op_req, page_set, busy_cnt, ops_seen, rx_pulses, refusals, oe_cnt, rewrite_ptr} = '0;
        {errors, num_checks} = '0;
        wp_n    = 1'b1;
        tx_byte = 8'h00;
        op_kind = OP_XFER;
        cycles(12);
        resetn = 1'b1;
        cycles(5);
        check("page_256", page_256, 0);
        check("powered_down", pdown, 0);
        check("so_oe_n", so_oe_n, 1);
        check("protect", protect, 0);
        // Each kind from transfer to chip erase rides on a frame whose release starts it.
        foreach (rows[r]) begin
            arm(rows[r].kind);
            tx_byte = rows[r].tx;
            mark    = rx_pulses;
            oe_mark = oe_cnt;
            prev    = ops_seen;
            frame(rows[r].m3, rows[r].mosi);
            check("rx_byte", rx_byte, rows[r].mosi);
            check("so_byte", miso, rows[r].tx);
            check("rx_pulses", rx_pulses - mark, 1);
            check("so_oe_n_drive", oe_cnt != oe_mark, 1);
            check("so_oe_n_idle", so_oe_n, 1);
            wait_op(prev);
            check("busy_len", last_len, rows[r].n);
            check("done_pulse", done_at_fall, 1);
        end
        // A request during a running operation is dropped.
        prev = ops_seen;
        arm(OP_XFER);
        frame(1'b0, 8'h69);
        cycles(3);
        op_req  = 1'b1;
        op_kind = OP_PROG;
        cycles(1);
        op_req = 1'b0;
        wait_op(prev);
        check("armed_after_busy", op_armed, 0);
        check("busy_len", last_len, N_XFER);
        // Protection engages, refuses every write kind, spares a compare.
        wp_n = 1'b0;
        for (int w = 0; w < 40 && protect !== 1'b1; w++) begin
            cycles(1);
        end
        check("protect_on", protect, 1);
        for (int k = OP_ERASE_PROG; k <= OP_CHIP_ERASE; k++) begin
            mark = refusals;
            arm(op_t'(k));
            frame(k[0], 8'h55);
            cycles(4);
            check("refused", refusals - mark, 1);
            check("busy_refused", busy, 0);
        end
        prev = ops_seen;
        arm(OP_COMP);
        frame(1'b0, 8'h53);
        wait_op(prev);
        check("comp_len", last_len, N_COMP);
        wp_n = 1'b1;
        for (int w = 0; w < 40 && protect !== 1'b0; w++) begin
            cycles(1);
        end
        check("protect_off", protect, 0);
        // Deep power-down and resume at their full lengths.
        prev = ops_seen;
        arm(OP_PDOWN);
        frame(1'b1, 8'hB9);
        wait_op(prev);
        check("pdown_len", last_len, DPD_CYC);
        check("powered_down", pdown, 1);
        prev = ops_seen;
        arm(OP_RESUME);
        frame(1'b0, 8'hAB);
        wait_op(prev);
        check("resume_len", last_len, RDPD_CYC);
        check("standby", pdown, 0);
        // Page size moves to 256; a long reset during a running transfer restores defaults.
        page_set = 1'b1;
        cycles(1);
        page_set = 1'b0;
        cycles(1);
        check("page_256_set", page_256, 1);
        arm(OP_XFER);
        frame(1'b0, 8'h0F);
        check("busy_before_reset", busy, 1);
        resetn = 1'b0;
        cycles(400);
        resetn = 1'b1;
        cycles(40);
        check("page_after_reset", page_256, 0);
        check("busy_after_reset", busy, 0);
        check("armed_after_reset", op_armed, 0);
        check("rewrite_ptr", rewrite_ptr, 12);
        check("rewrite_due", rewrite_ptr < REWRITE_SPAN, 1);
        end_of_test();
    end
endmodule
`default_nettype wire
